/* File: common/pesr_pkg.sv */
// Purpose: Constants for the port event status register bank
// Assumes: Four channels, one byte per event register
// Notes:   Command codes are the byte addresses seen on the link
// ==========================================================
// Package
package pesr_pkg;
   // ==========================================================
   // Command codes: peek reads, take reads and clears
   localparam logic [7:0] CMD_POWER_PEEK  = 8'h02;
   localparam logic [7:0] CMD_POWER_TAKE  = 8'h03;
   localparam logic [7:0] CMD_DETECT_PEEK = 8'h04;
   localparam logic [7:0] CMD_DETECT_TAKE = 8'h05;
   localparam logic [7:0] CMD_FAULT_PEEK  = 8'h06;
   localparam logic [7:0] CMD_FAULT_TAKE  = 8'h07;
   // Answer for an unmapped code
   localparam logic [7:0] RD_UNMAPPED     = 8'h00;

   // ==========================================================
   // Field positions inside each event byte
   localparam int CH_N         = 4;
   localparam int HI_FIELD_LSB = 4;  // Good, class, disconnect
   localparam int LO_FIELD_LSB = 0;  // Enable, detect, overload

   // ==========================================================
   // Reset values
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [7:0] SUMM_RESET  = 8'h00;

   // ==========================================================
   // Summary bit positions, shared with the mask
   localparam int SUM_PEC  = 0;
   localparam int SUM_PGC  = 1;
   localparam int SUM_DISF = 2;
   localparam int SUM_DETC = 3;
   localparam int SUM_CLSC = 4;
   localparam int SUM_OVLD = 5;

   // Which event register a command code selects
   typedef enum logic [1:0] {
      PESR_SEL_NONE,
      PESR_SEL_POWER,
      PESR_SEL_DETECT,
      PESR_SEL_FAULT
   } pesr_sel_e;
endpackage : pesr_pkg

/* File: verilog/pesr_top.sv */
// Purpose: Per-channel power, detection and fault event flags,
//          read over a command link in its own clock domain
// Assumes: Event inputs are one-cycle pulses on I_CORE_CLK;
//          the link party waits for O_CMD_READY
// Notes:   Interrupt output is active low and built from the
//          summary byte gated by the mask pins
`timescale 1ns/1ps

module pesr_top (
   // Core domain
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST,
   input  wire logic [3:0]  I_GOOD_CHANGE,
   input  wire logic [3:0]  I_ENABLE_CHANGE,
   input  wire logic [3:0]  I_CLASS_DONE,
   input  wire logic [3:0]  I_CLASS_CHANGED,
   input  wire logic [3:0]  I_DETECT_DONE,
   input  wire logic [3:0]  I_DETECT_CHANGED,
   input  wire logic [3:0]  I_DISCONNECT,
   input  wire logic [3:0]  I_OVERLOAD_TIMEOUT,
   input  wire logic [3:0]  I_CHANNEL_OFF,
   input  wire logic        I_CLASS_CHANGE_SELECT,
   input  wire logic        I_DETECT_CHANGE_SELECT,
   input  wire logic [7:0]  I_INT_MASK,
   output logic      [7:0]  O_INT_SUMMARY,
   output logic             O_INT_N,
   // Link domain
   input  wire logic        I_LINK_CLK,
   input  wire logic        I_CMD_VALID,
   input  wire logic [7:0]  I_CMD_CODE,
   output logic             O_CMD_READY,
   output logic      [7:0]  O_RD_DATA,
   output logic             O_RD_VALID
);

   // ==========================================================
   // Decoding

   // Maps a command code to the event register it selects
   function automatic pesr_pkg::pesr_sel_e sel_of(
      input logic [7:0] code
   );
      case (code)
         pesr_pkg::CMD_POWER_PEEK,
         pesr_pkg::CMD_POWER_TAKE:  sel_of = pesr_pkg::PESR_SEL_POWER;
         pesr_pkg::CMD_DETECT_PEEK,
         pesr_pkg::CMD_DETECT_TAKE: sel_of = pesr_pkg::PESR_SEL_DETECT;
         pesr_pkg::CMD_FAULT_PEEK,
         pesr_pkg::CMD_FAULT_TAKE:  sel_of = pesr_pkg::PESR_SEL_FAULT;
         default:                   sel_of = pesr_pkg::PESR_SEL_NONE;
      endcase
   endfunction : sel_of

   // Take codes are the odd member of each pair
   function automatic logic is_take(
      input logic [7:0] code
   );
      is_take = code[0] &&
                (sel_of(code) != pesr_pkg::PESR_SEL_NONE);
   endfunction : is_take

   // ==========================================================
   // State

   typedef struct packed {
      logic       req_meta;  // First stage, read by req_sync only
      logic       req_sync;
      logic       req_seen;
      logic       ack_tgl;
      logic [7:0] rd_data;   // Held stable until the next request
      logic [7:0] power;
      logic [7:0] detect;
      logic [7:0] fault;
      logic [7:0] summ;
      logic       int_n;
   } pesr_core_s;

   typedef struct packed {
      logic       rst_meta;  // Reset synchroniser, first stage
      logic       rst_sync;
      logic       req_tgl;
      logic [7:0] code;      // Held while busy, read by core
      logic       busy;
      logic       ack_meta;  // First stage, read by ack_sync only
      logic       ack_sync;
      logic       ack_seen;
      logic [7:0] rd_data;
      logic       rd_valid;
   } pesr_link_s;

   localparam pesr_core_s CORE_RESET = '{
      req_meta: 1'b0,
      req_sync: 1'b0,
      req_seen: 1'b0,
      ack_tgl:  1'b0,
      rd_data:  pesr_pkg::EVENT_RESET,
      power:    pesr_pkg::EVENT_RESET,
      detect:   pesr_pkg::EVENT_RESET,
      fault:    pesr_pkg::EVENT_RESET,
      summ:     pesr_pkg::SUMM_RESET,
      int_n:    1'b1
   };

   pesr_core_s c_q;
   pesr_core_s c_d;
   pesr_link_s l_q;
   pesr_link_s l_d;

   logic [7:0]          power_set;
   logic [7:0]          detect_set;
   logic [7:0]          fault_set;
   logic [7:0]          off_mask;
   logic [3:0]          class_src;
   logic [3:0]          detect_src;
   pesr_pkg::pesr_sel_e sel;
   logic                take;

   // ==========================================================
   // Event sources

   // Select control picks cycle-ran or result-changed pulses
   assign class_src  = I_CLASS_CHANGE_SELECT ?
                       I_CLASS_CHANGED : I_CLASS_DONE;
   assign detect_src = I_DETECT_CHANGE_SELECT ?
                       I_DETECT_CHANGED : I_DETECT_DONE;

   // Channel n lands at bit n-1 of the low and high nibbles
   genvar g;
   generate
      for (g = 0; g < pesr_pkg::CH_N; g++) begin : g_ch
         assign power_set[pesr_pkg::HI_FIELD_LSB + g]  = I_GOOD_CHANGE[g];
         assign power_set[pesr_pkg::LO_FIELD_LSB + g]  = I_ENABLE_CHANGE[g];
         assign detect_set[pesr_pkg::HI_FIELD_LSB + g] = class_src[g];
         assign detect_set[pesr_pkg::LO_FIELD_LSB + g] = detect_src[g];
         assign fault_set[pesr_pkg::HI_FIELD_LSB + g]  = I_DISCONNECT[g];
         assign fault_set[pesr_pkg::LO_FIELD_LSB + g]  = I_OVERLOAD_TIMEOUT[g];
         assign off_mask[pesr_pkg::HI_FIELD_LSB + g]   = I_CHANNEL_OFF[g];
         assign off_mask[pesr_pkg::LO_FIELD_LSB + g]   = I_CHANNEL_OFF[g];
      end
   endgenerate

   // Code is stable while the request toggle travels
   assign sel  = sel_of(l_q.code);
   assign take = is_take(l_q.code);

   // ==========================================================
   // Core domain next state

   // Sets are ORed in after every clear so no event is lost
   always_comb begin
      c_d          = c_q;
      c_d.req_meta = l_q.req_tgl;
      c_d.req_sync = c_q.req_meta;

      if (c_q.req_sync != c_q.req_seen) begin
         c_d.req_seen = c_q.req_sync;
         c_d.ack_tgl  = ~c_q.ack_tgl;
         // Snapshot taken before any clear, so take returns it
         case (sel)
            pesr_pkg::PESR_SEL_POWER:  c_d.rd_data = c_q.power;
            pesr_pkg::PESR_SEL_DETECT: c_d.rd_data = c_q.detect;
            pesr_pkg::PESR_SEL_FAULT:  c_d.rd_data = c_q.fault;
            default:                   c_d.rd_data = pesr_pkg::RD_UNMAPPED;
         endcase
         // Only the flag byte is cleared; duration counters
         // live in the engines and are not touched here
         if (take) begin
            case (sel)
               pesr_pkg::PESR_SEL_POWER:  c_d.power  = pesr_pkg::EVENT_RESET;
               pesr_pkg::PESR_SEL_DETECT: c_d.detect = pesr_pkg::EVENT_RESET;
               pesr_pkg::PESR_SEL_FAULT:  c_d.fault  = pesr_pkg::EVENT_RESET;
               default:                   c_d.power  = c_d.power;
            endcase
         end
      end

      // Channel off wipes its detect and fault bits, not power; a same-cycle set still wins
      c_d.detect = c_d.detect & ~off_mask;
      c_d.fault  = c_d.fault & ~off_mask;
      c_d.power  = c_d.power | power_set;
      c_d.detect = c_d.detect | detect_set;
      c_d.fault  = c_d.fault | fault_set;

      // Summary follows flags whatever the mask says
      c_d.summ                    = pesr_pkg::SUMM_RESET;
      c_d.summ[pesr_pkg::SUM_PEC]  = |c_d.power[3:0];
      c_d.summ[pesr_pkg::SUM_PGC]  = |c_d.power[7:4];
      c_d.summ[pesr_pkg::SUM_DISF] = |c_d.fault[7:4];
      c_d.summ[pesr_pkg::SUM_DETC] = |c_d.detect[3:0];
      c_d.summ[pesr_pkg::SUM_CLSC] = |c_d.detect[7:4];
      c_d.summ[pesr_pkg::SUM_OVLD] = |c_d.fault[3:0];

      // Cleared register drops out, releasing the pin
      c_d.int_n = ~|(c_d.summ & I_INT_MASK);
   end

   // Core registers with synchronous reset
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         c_q <= CORE_RESET;
      end else begin
         c_q <= c_d;
      end
   end

   // ==========================================================
   // Link domain next state

   // Reset reaches the link through two flops; the link clock
   // may stop between commands, so nothing waits on it
   always_comb begin
      l_d          = l_q;
      l_d.rst_meta = I_RST;
      l_d.rst_sync = l_q.rst_meta;
      l_d.ack_meta = c_q.ack_tgl;
      l_d.ack_sync = l_q.ack_meta;
      l_d.rd_valid = 1'b0;

      // Accept one command, then hold it until answered
      if (I_CMD_VALID && !l_q.busy) begin
         l_d.code    = I_CMD_CODE;
         l_d.req_tgl = ~l_q.req_tgl;
         l_d.busy    = 1'b1;
      end

      // Core data is stable once its ack toggle is seen
      if (l_q.ack_sync != l_q.ack_seen) begin
         l_d.ack_seen = l_q.ack_sync;
         l_d.rd_data  = c_q.rd_data;
         l_d.rd_valid = 1'b1;
         l_d.busy     = 1'b0;
      end

      if (l_q.rst_sync) begin
         l_d.req_tgl  = 1'b0;
         l_d.code     = pesr_pkg::RD_UNMAPPED;
         l_d.busy     = 1'b0;
         l_d.ack_meta = 1'b0;
         l_d.ack_sync = 1'b0;
         l_d.ack_seen = 1'b0;
         l_d.rd_data  = pesr_pkg::EVENT_RESET;
         l_d.rd_valid = 1'b0;
      end
   end

   // Link registers
   always_ff @(posedge I_LINK_CLK) begin
      l_q <= l_d;
   end

   // ==========================================================
   // Outputs

   // Ready is a handshake term and may be combinational
   assign O_CMD_READY   = ~l_q.busy & ~l_q.rst_sync;
   assign O_RD_DATA     = l_q.rd_data;
   assign O_RD_VALID    = l_q.rd_valid;
   assign O_INT_SUMMARY = c_q.summ;
   assign O_INT_N       = c_q.int_n;

endmodule : pesr_top

/* File: sim/pesr_top_chk.sv */
// Purpose: Port assertions for the event register bank
// Assumes: Link clock may stand still between commands
// Notes:   Bound onto every pesr_top instance
`timescale 1ns/1ps
module pesr_top_chk (
   input wire logic       I_CORE_CLK,
   input wire logic       I_RST,
   input wire logic       I_CLASS_CHANGE_SELECT,
   input wire logic       I_DETECT_CHANGE_SELECT,
   input wire logic       O_INT_N,
   input wire logic [3:0] I_GOOD_CHANGE,
   input wire logic [3:0] I_ENABLE_CHANGE,
   input wire logic [3:0] I_CLASS_DONE,
   input wire logic [3:0] I_CLASS_CHANGED,
   input wire logic [3:0] I_DETECT_DONE,
   input wire logic [3:0] I_DETECT_CHANGED,
   input wire logic [3:0] I_DISCONNECT,
   input wire logic [3:0] I_OVERLOAD_TIMEOUT,
   input wire logic [7:0] I_INT_MASK,
   input wire logic [7:0] O_INT_SUMMARY,
   input wire logic       I_LINK_CLK,
   input wire logic       I_CMD_VALID,
   input wire logic       O_CMD_READY,
   input wire logic       O_RD_VALID
);
   // ==========================================================
   // Core side: an event shows in its summary bit one edge later
   chk_good_sets_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |I_GOOD_CHANGE |=> O_INT_SUMMARY[1]) else $error("good change lost");
   chk_enable_sets_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |I_ENABLE_CHANGE |=> O_INT_SUMMARY[0]) else $error("enable change lost");
   // Select picks which source counts; only the picked source is checked
   chk_class_sel_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |(I_CLASS_CHANGE_SELECT ? I_CLASS_CHANGED : I_CLASS_DONE) |=> O_INT_SUMMARY[4]) else $error("class lost");
   chk_detect_sel_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |(I_DETECT_CHANGE_SELECT ? I_DETECT_CHANGED : I_DETECT_DONE) |=> O_INT_SUMMARY[3]) else $error("detect lost");
   chk_disc_sets_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |I_DISCONNECT |=> O_INT_SUMMARY[2]) else $error("disconnect lost");
   chk_ovld_sets_sum: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      |I_OVERLOAD_TIMEOUT |=> O_INT_SUMMARY[5]) else $error("overload lost");
   // Only six summary classes live here; the top two bits stay low
   chk_sum_top_low: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      O_INT_SUMMARY[7:6] == 2'b00) else $error("unused summary bit set");
   // Mask only gates the pin, taken with the summary on the same edge
   chk_mask_gates_int: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      1 |=> O_INT_N == ~|(O_INT_SUMMARY & $past(I_INT_MASK))) else $error("interrupt pin wrong");
   // ==========================================================
   // Link side: one command out, answered in bounded time
   sequence cmd_take;
      I_CMD_VALID && O_CMD_READY;
   endsequence
   sequence answer_due;
      ##[3:20] O_RD_VALID;
   endsequence
   chk_take_answered: assert property (@(posedge I_LINK_CLK) disable iff (I_RST)
      cmd_take |-> answer_due) else $error("no answer");
   chk_ready_drops: assert property (@(posedge I_LINK_CLK) disable iff (I_RST)
      cmd_take |=> !O_CMD_READY) else $error("second command accepted");
endmodule : pesr_top_chk

bind pesr_top pesr_top_chk i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .O_INT_N(O_INT_N),
   .I_CLASS_CHANGE_SELECT(I_CLASS_CHANGE_SELECT), .I_DETECT_CHANGE_SELECT(I_DETECT_CHANGE_SELECT),
   .I_GOOD_CHANGE(I_GOOD_CHANGE), .I_ENABLE_CHANGE(I_ENABLE_CHANGE), .I_CLASS_DONE(I_CLASS_DONE),
   .I_CLASS_CHANGED(I_CLASS_CHANGED), .I_DETECT_DONE(I_DETECT_DONE), .I_DETECT_CHANGED(I_DETECT_CHANGED),
   .I_DISCONNECT(I_DISCONNECT), .I_OVERLOAD_TIMEOUT(I_OVERLOAD_TIMEOUT),
   .I_INT_MASK(I_INT_MASK), .O_INT_SUMMARY(O_INT_SUMMARY),
   .I_LINK_CLK(I_LINK_CLK), .I_CMD_VALID(I_CMD_VALID), .O_CMD_READY(O_CMD_READY), .O_RD_VALID(O_RD_VALID));

/* File: sim/pesr_host.sv */
// Purpose: Host model issuing command reads on the link
// Assumes: One command outstanding at a time
// Notes:   Link clock runs through reset, then only around commands
`timescale 1ns/1ps
module pesr_host (
   input  wire logic       i_cmd_ready,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_valid,
   output logic            o_link_clk = 1'b0,
   output logic            o_cmd_valid = 1'b0,
   output logic      [7:0] o_cmd_code = 8'h5A
);
   logic run = 1'b1;
   // Clock stands low outside commands, as a real host may do
   always #24 o_link_clk = run ? ~o_link_clk : 1'b0;

   // One command: wait ready, hold until taken, collect the answer
   task automatic issue(input logic [7:0] code, output logic [7:0] data, output logic ok);
      int n;
      run = 1'b1;
      ok = 1'b0;
      n = 0;
      @(negedge o_link_clk);
      while (!i_cmd_ready && n < 40) begin
         @(negedge o_link_clk);
         n++;
      end
      o_cmd_valid = 1'b1;
      o_cmd_code = code;
      @(negedge o_link_clk);
      o_cmd_valid = 1'b0;
      o_cmd_code = ~code;  // Released code must not look valid
      n = 0;
      while (!ok && n < 20) begin
         @(negedge o_link_clk);
         ok = i_rd_valid;
         n++;
      end
      data = i_rd_data;
      @(negedge o_link_clk);
      run = 1'b0;
   endtask : issue
endmodule : pesr_host

/* File: sim/pesr_top_bench.sv */
// Purpose: Self-checking bench for the event register bank
// Assumes: Inputs change on the falling core edge
// Notes:   Rows cover every event source; odd cases follow
`timescale 1ns/1ps
module pesr_top_bench;
   typedef struct {int src; logic [3:0] ch; logic sel; logic [7:0] code, exp, sum;} pesr_row_s;
   logic       clk = 1'b0, rst = 1'b1, sel = 1'b0, int_n, ready, rvalid, lclk, cvalid;
   logic [3:0] ev [8] = '{default: 4'h0};
   logic [3:0] off = 4'h0;
   logic [7:0] mask = 8'hFF, sum, rdat, ccode;
   int         fail_count = 0, check_count = 0, cyc = 0;
   // Source index: good, enable, class done, class changed, detect done, detect changed, disconnect, overload
   pesr_row_s  rows [8] = '{'{0, 4'h1, 0, 8'h02, 8'h10, 8'h02}, '{1, 4'h8, 0, 8'h02, 8'h08, 8'h01},
      '{2, 4'h2, 0, 8'h04, 8'h20, 8'h10}, '{3, 4'h4, 1, 8'h04, 8'h40, 8'h10}, '{4, 4'h1, 0, 8'h04, 8'h01, 8'h08},
      '{5, 4'h8, 1, 8'h04, 8'h08, 8'h08}, '{6, 4'h4, 0, 8'h06, 8'h40, 8'h04}, '{7, 4'hF, 0, 8'h06, 8'h0F, 8'h20}};

   pesr_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_GOOD_CHANGE(ev[0]), .I_ENABLE_CHANGE(ev[1]),
      .I_CLASS_DONE(ev[2]), .I_CLASS_CHANGED(ev[3]), .I_DETECT_DONE(ev[4]), .I_DETECT_CHANGED(ev[5]),
      .I_DISCONNECT(ev[6]), .I_OVERLOAD_TIMEOUT(ev[7]), .I_CHANNEL_OFF(off), .I_CLASS_CHANGE_SELECT(sel),
      .I_DETECT_CHANGE_SELECT(sel), .I_INT_MASK(mask), .O_INT_SUMMARY(sum), .O_INT_N(int_n),
      .I_LINK_CLK(lclk), .I_CMD_VALID(cvalid), .I_CMD_CODE(ccode), .O_CMD_READY(ready),
      .O_RD_DATA(rdat), .O_RD_VALID(rvalid));
   pesr_host i_host (.i_cmd_ready(ready), .i_rd_data(rdat), .i_rd_valid(rvalid), .o_link_clk(lclk),
      .o_cmd_valid(cvalid), .o_cmd_code(ccode));

   always #50 clk = ~clk;
   // Hang guard: the whole run needs a few hundred cycles, well under 6000
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic rd(input logic [7:0] code, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      i_host.issue(code, d, ok);
      cmp({7'h00, ok}, 8'h01);
      cmp(d, exp);
   endtask : rd
   task automatic pulse(input int src, input logic [3:0] ch);
      @(negedge clk) ev[src] = ch;
      @(negedge clk) ev[src] = 4'h0;
   endtask : pulse
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      cmp(sum, 8'h00);
      cmp({7'h00, int_n}, 8'h01);
      rd(8'h02, 8'h00);
      // Table: each source sets its flag, peek keeps it, take clears it
      foreach (rows[i]) begin
         @(negedge clk) sel = rows[i].sel;
         pulse(rows[i].src, rows[i].ch);
         cmp(sum, rows[i].sum);
         cmp({7'h00, int_n}, 8'h00);
         rd(rows[i].code, rows[i].exp);
         rd(rows[i].code, rows[i].exp);
         rd(rows[i].code + 8'h01, rows[i].exp);
         rd(rows[i].code, 8'h00);
         @(negedge clk);
         cmp(sum, 8'h00);
         cmp({7'h00, int_n}, 8'h01);
      end
      // Source not picked by the select leaves its flag clear
      pulse(3, 4'h1);
      pulse(5, 4'h1);
      sel = 1'b1;
      pulse(2, 4'h1);
      pulse(4, 4'h1);
      cmp(sum, 8'h00);
      // Masked disconnect still reaches the summary, pin stays released
      mask = 8'h00;
      pulse(6, 4'h2);
      cmp(sum, 8'h04);
      cmp({7'h00, int_n}, 8'h01);
      mask = 8'hFF;
      @(negedge clk);
      cmp({7'h00, int_n}, 8'h00);
      // Channel off clears detect and fault bits, not power bits
      pulse(0, 4'h2);
      pulse(5, 4'h2);
      pulse(6, 4'h2);
      pulse(7, 4'h2);
      @(negedge clk) off = 4'h2;
      @(negedge clk) off = 4'h0;
      rd(8'h06, 8'h00);
      rd(8'h04, 8'h00);
      // Unmapped codes answer zero and disturb nothing
      rd(8'h01, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h02, 8'h20);
      // Event held high across a take survives the clear
      @(negedge clk) ev[0] = 4'h1;
      rd(8'h03, 8'h30);
      @(negedge clk) ev[0] = 4'h0;
      rd(8'h02, 8'h10);
      // Reset in mid-run; link clock kept running so both sides see it
      i_host.run = 1'b1;
      @(negedge clk) rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      cmp(sum, 8'h00);
      cmp({7'h00, int_n}, 8'h01);
      rd(8'h02, 8'h00);
      give_verdict();
   end
endmodule : pesr_top_bench
